// ===== design/pmc_params.svh
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

// Register byte offsets
`define PMC_OFS_CAP 8'h90
`define PMC_OFS_CSR 8'h94
`define PMC_OFS_ISTAT 8'hc0
`define PMC_OFS_IMASK 8'hc4

// Capability word fields
`define PMC_CAP_ID 8'h01
`define PMC_NEXT_PTR 8'ha8
`define PMC_VERSION 3'h2
`define PMC_AUX_CUR 3'h1
`define PMC_EVT_SUPPORT 5'h19

// Control and status word fields
`define PMC_PS_D0 2'h0
`define PMC_PS_D3 2'h3
`define PMC_PS_RESET 2'h0
`define PMC_PS_LSB 0
`define PMC_EN_BIT 8
`define PMC_ST_BIT 15

// Interrupt status bits
`define PMC_IRQ_WAKE 0
`define PMC_IRQ_DRST 1
`define PMC_IRQ_W 2

// Internal reset pulse length in cycles
`define PMC_RST_CYC 4

`endif

// ===== design/pmc_pkg.sv
`default_nettype none
package pmc_pkg;

    typedef enum logic [0:0] {RS_IDLE, RS_HOLD} pmc_rst_state_t;

    typedef struct packed {
        logic [1:0] pstate;
        logic evt_en;
        logic evt_st;
    } pmc_csr_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [3:0] strb;
    } pmc_acc_t;

endpackage
`default_nettype wire

// ===== design/pmc_regs.sv
// Overview of operation
// - Next capability pointer reads fixed A8h.
// - Version field reads 010, revision 2.0 compliant.
// - Event clock bit reads zero; no bus clock needed.
// - Special initialisation bit reads zero.
// - D1 and D2 support bits read zero.
// - Event support field reads 11001: D3 cold, D3 hot, D0.
// - Power state: D0 is 00, D3 is 11, resets to 00.
// - Writes of state 01 or 10 are discarded.
// - D3 to D0 write pulses internal reset, bus reset untouched.
// - Event enable is sticky read-write, resets to 0.
// - Data select, scale and data byte all read zero.
// - Secondary B2/B3 support bit reads zero.
// - Secondary power/clock control enable bit reads zero.
`include "pmc_params.svh"
`default_nettype none
module pmc_regs
    import pmc_pkg::*;
#(
    parameter int RST_CYC = `PMC_RST_CYC,
    parameter logic [7:0] CAP_ID = `PMC_CAP_ID
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pcen,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wake_req,
    output logic wake_event_out_n,
    output logic int_reset_n,
    output logic [1:0] power_state,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////
    // Bus decode

    pmc_acc_t acc;
    pmc_csr_t csr;
    pmc_rst_state_t rst_state_r;
    logic [31:0] cap_word;
    logic [31:0] csr_word;
    logic [31:0] rd_val;
    logic hit;
    logic wake_s;
    logic [1:0] ps_r;
    logic [1:0] ps_nxt;
    logic ps_wr;
    logic d3_to_d0;
    logic [7:0] rst_cnt_r;
    logic [`PMC_IRQ_W-1:0] istat;
    logic [`PMC_IRQ_W-1:0] imask_r;
    logic [`PMC_IRQ_W-1:0] istat_clr;
    logic [`PMC_IRQ_W-1:0] istat_set;
    logic [0:0] evst;
    logic evst_clr;
    logic evt_en_r;
    logic pready_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic wake_n_r;
    logic int_reset_n_r;
    logic irq_r;

    // One wait state: the answer comes from a flop
    assign acc.rd = psel && penable && !pwrite && !pready_r;
    assign acc.wr = psel && penable && pwrite && !pready_r;
    assign acc.addr = paddr;
    assign acc.wdata = pwdata;
    assign acc.strb = pstrb;

    always_comb
    begin
        case (acc.addr)
            `PMC_OFS_CAP, `PMC_OFS_CSR, `PMC_OFS_ISTAT, `PMC_OFS_IMASK:
                hit = 1'b1;
            default:
                hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Read words

    assign cap_word = {`PMC_EVT_SUPPORT, 1'b0, 1'b0, `PMC_AUX_CUR,
                       1'b0, 1'b0, 1'b0, `PMC_VERSION,
                       `PMC_NEXT_PTR, CAP_ID};

    assign csr.pstate = ps_r;
    assign csr.evt_en = evt_en_r;
    assign csr.evt_st = evst[0];

    assign csr_word = {8'h00, 1'b0, 1'b0, 6'h00, csr.evt_st, 2'h0,
                       4'h0, csr.evt_en, 6'h00, csr.pstate};

    always_comb
    begin
        case (acc.addr)
            `PMC_OFS_CAP: rd_val = cap_word;
            `PMC_OFS_CSR: rd_val = csr_word;
            `PMC_OFS_ISTAT: rd_val = {30'h0, istat};
            `PMC_OFS_IMASK: rd_val = {30'h0, imask_r};
            default: rd_val = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0;
            pslverr_r <= 1'b0;
        end
        else if (pcen)
        begin
            pready_r <= acc.rd || acc.wr;
            pslverr_r <= (acc.rd || acc.wr) && !hit;
            if (acc.rd)
                prdata_r <= rd_val;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Power state

    assign ps_wr = acc.wr && acc.addr == `PMC_OFS_CSR && acc.strb[0];

    always_comb
    begin
        ps_nxt = ps_r;
        if (ps_wr)
        begin
            case (acc.wdata[`PMC_PS_LSB+:2])
                `PMC_PS_D0, `PMC_PS_D3:
                    ps_nxt = acc.wdata[`PMC_PS_LSB+:2];
                default:
                    ps_nxt = ps_r;
            endcase
        end
    end

    assign d3_to_d0 = ps_r == `PMC_PS_D3 && ps_nxt == `PMC_PS_D0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ps_r <= `PMC_PS_RESET;
        else if (pcen)
            ps_r <= ps_nxt;
    end

    ////////////////////////////////////////////////////////////////////
    // Internal reset

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rst_state_r <= RS_IDLE;
            rst_cnt_r <= 8'h00;
            int_reset_n_r <= 1'b1;
        end
        else if (pcen)
        begin
            case (rst_state_r)
                RS_IDLE:
                begin
                    if (d3_to_d0)
                    begin
                        rst_state_r <= RS_HOLD;
                        rst_cnt_r <= 8'(RST_CYC - 1);
                        int_reset_n_r <= 1'b0;
                    end
                end
                RS_HOLD:
                begin
                    if (rst_cnt_r == 8'h00)
                    begin
                        rst_state_r <= RS_IDLE;
                        int_reset_n_r <= 1'b1;
                    end
                    else
                        rst_cnt_r <= rst_cnt_r - 8'h01;
                end
                default:
                    rst_state_r <= RS_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Wake event enable and status

    pmc_sync2 u_wake_sync (
        .clk(pclk),
        .rst_n(presetn),
        .ce(pcen),
        .d(wake_req),
        .q(wake_s)
    );

    // enable kept across the internal reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            evt_en_r <= 1'b0;
        else if (pcen && acc.wr && acc.addr == `PMC_OFS_CSR && acc.strb[1])
            evt_en_r <= acc.wdata[`PMC_EN_BIT];
    end

    // set by wake, write one clears
    assign evst_clr = acc.wr && acc.addr == `PMC_OFS_CSR && acc.strb[1]
                      && acc.wdata[`PMC_ST_BIT];

    pmc_sticky #(
        .W(1)
    ) u_evst (
        .clk(pclk),
        .rst_n(presetn),
        .ce(pcen),
        .set(wake_s),
        .clr(evst_clr),
        .q(evst)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wake_n_r <= 1'b1;
        else if (pcen)
            wake_n_r <= !(evst[0] && evt_en_r);
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupts

    assign istat_set[`PMC_IRQ_WAKE] = wake_s;
    assign istat_set[`PMC_IRQ_DRST] = d3_to_d0;
    assign istat_clr = (acc.wr && acc.addr == `PMC_OFS_ISTAT && acc.strb[0])
                       ? acc.wdata[`PMC_IRQ_W-1:0] : '0;

    pmc_sticky #(
        .W(`PMC_IRQ_W)
    ) u_istat (
        .clk(pclk),
        .rst_n(presetn),
        .ce(pcen),
        .set(istat_set),
        .clr(istat_clr),
        .q(istat)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            imask_r <= '0;
            irq_r <= 1'b0;
        end
        else if (pcen)
        begin
            if (acc.wr && acc.addr == `PMC_OFS_IMASK && acc.strb[0])
                imask_r <= acc.wdata[`PMC_IRQ_W-1:0];
            irq_r <= |(istat & imask_r);
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign wake_event_out_n = wake_n_r;
    assign int_reset_n = int_reset_n_r;
    assign power_state = ps_r;
    assign irq = irq_r;

    ////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_wr_csr;
        pcen && acc.wr && acc.addr == `PMC_OFS_CSR && acc.strb[0];
    endsequence
    sequence s_rst_low;
        !int_reset_n ##1 !int_reset_n;
    endsequence
    property p_next_ptr;
        @(posedge pclk) disable iff (!presetn)
        cap_word[15:8] == 8'ha8;
    endproperty
    a_next_ptr: assert property (p_next_ptr)
        else $error("Next pointer wrong");
    property p_version;
        @(posedge pclk) disable iff (!presetn)
        cap_word[18:16] == 3'h2 && !cap_word[19] && !cap_word[21];
    endproperty
    a_version: assert property (p_version)
        else $error("Version, clock or init bit wrong");
    property p_support;
        @(posedge pclk) disable iff (!presetn)
        cap_word[31:25] == 7'h64;
    endproperty
    a_support: assert property (p_support)
        else $error("Power state support bits wrong");
    property p_csr_zero;
        @(posedge pclk) disable iff (!presetn)
        csr_word[31:22] == 10'h0 && csr_word[14:9] == 6'h0;
    endproperty
    a_csr_zero: assert property (p_csr_zero)
        else $error("Data or bus support bits not zero");
    property p_bad_state;
        @(posedge pclk) disable iff (!presetn)
        s_wr_csr ##0 (acc.wdata[1:0] == 2'h1 || acc.wdata[1:0] == 2'h2)
        |=> $stable(ps_r);
    endproperty
    a_bad_state: assert property (p_bad_state)
        else $error("Unimplemented state accepted");
    property p_d3_d0;
        @(posedge pclk) disable iff (!presetn)
        s_wr_csr ##0 (ps_r == 2'h3 && acc.wdata[1:0] == 2'h0)
        |=> s_rst_low;
    endproperty
    a_d3_d0: assert property (p_d3_d0)
        else $error("No internal reset on D3 to D0");
    property p_no_spurious_rst;
        @(posedge pclk) disable iff (!presetn)
        $fell(int_reset_n) |-> $past(ps_r) == 2'h3 && ps_r == 2'h0;
    endproperty
    a_no_spurious_rst: assert property (p_no_spurious_rst)
        else $error("Internal reset without D3 exit");
    property p_evst_set;
        @(posedge pclk) disable iff (!presetn)
        pcen && wake_s |=> evst[0];
    endproperty
    a_evst_set: assert property (p_evst_set)
        else $error("Wake did not set event status");
    property p_out;
        @(posedge pclk) disable iff (!presetn)
        pcen |=> wake_event_out_n == !($past(evst[0]) && $past(evt_en_r));
    endproperty
    a_out: assert property (p_out)
        else $error("Event output mismatch");
    property p_en_survive;
        @(posedge pclk) disable iff (!presetn)
        $fell(int_reset_n) |-> ##[1:2] $stable(evt_en_r) || pcen && acc.wr;
    endproperty
    a_en_survive: assert property (p_en_survive)
        else $error("Enable lost on internal reset");
endmodule
`default_nettype wire

// ===== design/pmc_sticky.sv
`default_nettype none
module pmc_sticky #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] q
);
    genvar i;

    // Set beats clear so a coincident event is kept
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    q[i] <= 1'b0;
                else if (ce)
                begin
                    if (set[i])
                        q[i] <= 1'b1;
                    else if (clr[i])
                        q[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ===== design/pmc_sync2.sv
`default_nettype none
module pmc_sync2 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic d,
    output logic q
);
    logic meta_r;

    // Only the second stage is visible to logic
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= 1'b0;
            q <= 1'b0;
        end
        else if (ce)
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ===== verif/pmc_wake_src.sv
`default_nettype none
module pmc_wake_src #(
    parameter int HOLD = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    output logic wake_req
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    ////////////////////////////////////////////////////////////////////////
    // wake level source
    // Held several cycles so the two-flop sync cannot miss it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 0;
            wake_req <= 1'b0;
        end
        else if (go)
        begin
            cnt <= HOLD;
            wake_req <= 1'b1;
        end
        else if (cnt > 1)
            cnt <= cnt - 1;
        else
        begin
            cnt <= 0;
            wake_req <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== verif/power_mgmt_capability_regs_bench.sv
`default_nettype none
module power_mgmt_capability_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RST_CYC = 3;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic go = 1'b0;
    logic pcen = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata, rd_data;
    logic pready, pslverr, err_flag, wake_req, wake_event_out_n;
    logic int_reset_n, irq;
    logic [1:0] power_state;
    int failures = 0;
    int check_count = 0;
    int low_cnt = 0;
    int base;

    always #2 pclk = ~pclk;

    pmc_regs #(.RST_CYC(RST_CYC)) i_dut (
        .pclk(pclk), .presetn(presetn), .pcen(pcen), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wake_req(wake_req),
        .wake_event_out_n(wake_event_out_n), .int_reset_n(int_reset_n),
        .power_state(power_state), .irq(irq)
    );

    pmc_wake_src i_wake (
        .pclk(pclk), .presetn(presetn), .go(go), .wake_req(wake_req)
    );

    always @(posedge pclk)
    begin
        if (int_reset_n === 1'b0)
            low_cnt <= low_cnt + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    task close_out;
        $display("failures=%0d check_count=%0d", failures, check_count);
        if (failures == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Entered just after a rising edge; ends one idle edge later
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            chk({31'h0, pready}, 32'h1);
        rd_data = prdata;
        err_flag = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd_data, exp);
    endtask

    task wake_pulse;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(8'h90, 32'hc842a801);
        rd_chk(8'h94, 32'h0);
        chk({30'h0, power_state}, 32'h0);
        // Unimplemented states from D0, then state 2 from D3
        for (int ps = 1; ps < 3; ps++)
        begin
            xfer(1'b1, 8'h94, ps);
            rd_chk(8'h94, 32'h0);
        end
        xfer(1'b1, 8'h94, 32'h3);
        rd_chk(8'h94, 32'h3);
        chk({30'h0, power_state}, 32'h3);
        xfer(1'b1, 8'h94, 32'h2);
        rd_chk(8'h94, 32'h3);
        base = low_cnt;
        xfer(1'b1, 8'h94, 32'h0);
        repeat (RST_CYC + 2) @(posedge pclk);
        chk(low_cnt - base, RST_CYC);
        chk({30'h0, power_state}, 32'h0);
        rd_chk(8'hc0, 32'h2);
        xfer(1'b1, 8'hc0, 32'h2);
        // Read-only fields must ignore ones
        xfer(1'b1, 8'h94, 32'hffff_7f00);
        rd_chk(8'h94, 32'h0000_0100);
        xfer(1'b1, 8'hc4, 32'h1);
        wake_pulse();
        chk({31'h0, wake_event_out_n}, 32'h0);
        chk({31'h0, irq}, 32'h1);
        rd_chk(8'h94, 32'h0000_8100);
        repeat (8) @(posedge pclk);
        xfer(1'b1, 8'h94, 32'h0000_8100);
        rd_chk(8'h94, 32'h0000_0100);
        chk({31'h0, wake_event_out_n}, 32'h1);
        xfer(1'b1, 8'hc0, 32'h3);
        chk({31'h0, irq}, 32'h0);
        // Wake with enable off: status sets, output stays high
        xfer(1'b1, 8'h94, 32'h0);
        xfer(1'b1, 8'hc4, 32'h0);
        wake_pulse();
        chk({31'h0, wake_event_out_n}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        rd_chk(8'h94, 32'h0000_8000);
        xfer(1'b1, 8'hc4, 32'h1);
        chk({31'h0, irq}, 32'h1);
        rd_chk(8'hc0, 32'h1);
        // Enable and status must outlast the internal reset
        xfer(1'b1, 8'h94, 32'h0000_0103);
        xfer(1'b1, 8'h94, 32'h0000_0100);
        repeat (RST_CYC + 2) @(posedge pclk);
        rd_chk(8'h94, 32'h0000_8100);
        chk({31'h0, wake_event_out_n}, 32'h0);
        // Enable low freezes the block: a wake leaves no trace
        xfer(1'b1, 8'h94, 32'h0000_8000);
        xfer(1'b1, 8'hc0, 32'h3);
        pcen <= 1'b0;
        wake_pulse();
        pcen <= 1'b1;
        rd_chk(8'h94, 32'h0);
        rd_chk(8'hc0, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // Unmapped place answers zero with an error
        xfer(1'b1, 8'h98, 32'hffff_ffff);
        chk({31'h0, err_flag}, 32'h1);
        rd_chk(8'h98, 32'h0);
        chk({31'h0, err_flag}, 32'h1);
        close_out();
    end

    // Tests need about 200 cycles; allow twenty times that
    initial
    begin
        #16000;
        failures++;
        close_out();
    end
endmodule
`default_nettype wire
